// *** hw/nbsp_top.sv ***
// What this block does
// - frame is start, eight data bits lsb first, ninth bit, stop
// - transmitted ninth bit comes from tx_ninth_bit control flag
// - received ninth bit goes to rx_ninth_bit; stop bit unchecked
// - writing serial_data_buffer starts a new transmit frame only while no frame is on the wire
// - tx_done_flag sets when the stop bit time begins
// - receiver starts a frame only while rx_enable_ctl is one; a frame under way still completes
// - accept frame only if rx_done_flag clear and filter passes
// - accepted frame loads buffer, ninth bit, sets rx_done_flag
// - rejected frame leaves buffer, ninth bit and flag alone
// - interrupt requested when an enabled done flag sets
// - prescale code selects clock divided by 12, 4 or 48
//
// Chosen here: the register offsets and the plain strobed port.
`include "nbsp_consts.svh"
`default_nettype none
module nbsp_top (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire nbsp_pkg::nbsp_addr_type addr,
  input  wire nbsp_pkg::nbsp_data_type wdata,
  input  wire logic                  wr_en,
  input  wire logic                  rd_en,
  output var  nbsp_pkg::nbsp_data_type rdata,
  input  wire logic                  rxd,
  output var  logic                  txd,
  output var  logic                  irq
);
  import nbsp_pkg::*;

  localparam logic [7:0] ctrl_rst_val = `NBSP_CTRL_RST;

  nbsp_rate_if rif ();

  logic              mp_en_reg;
  logic              rx_en_reg;
  logic              tx9_reg;
  logic              rx9_reg;
  logic              tx_done_reg;
  logic              rx_done_reg;
  logic [7:0]        reload_reg;
  logic [2:0]        rate_reg;
  logic [1:0]        istat_reg;
  logic [1:0]        istat_next;
  logic [1:0]        ien_reg;
  logic              irq_reg;
  nbsp_data_type     rdata_reg;
  logic              wr_ctl;
  logic              wr_data;
  logic              ovf;
  logic              tx_busy_reg;
  logic [10:0]       tx_shift_reg;
  logic [3:0]        tx_idx_reg;
  logic              tx_half_reg;
  logic              txd_reg;
  logic              tx9_sent_reg;
  logic              tx_load;
  logic              tx_set;
  nbsp_rx_state_type rx_state_reg;
  logic [8:0]        rx_shift_reg;
  logic [3:0]        rx_cnt_reg;
  logic              rx_half_reg;
  logic [7:0]        rx_buf_reg;
  logic              rx_finish;
  logic              rx_ok;
  logic              rx_accept;

  // ----------------------------------------------------------------
  // bit-rate timer
  // ----------------------------------------------------------------
  assign rif.reload       = reload_reg;
  assign rif.system_clock_sel   = rate_reg[`NBSP_RATE_SYSTEM_CLOCK];
  assign rif.prescale_sel = rate_reg[`NBSP_RATE_PS_HI:`NBSP_RATE_PS_LO];
  assign ovf              = rif.ovf;

  nbsp_rate u_rate (
    .clk   (clk),
    .rst_n (rst_n),
    .rif   (rif)
  );

  // ----------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------
  assign wr_ctl  = wr_en && (addr == `NBSP_OFS_CTRL);
  assign wr_data = wr_en && (addr == `NBSP_OFS_DATA);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mp_en_reg <= ctrl_rst_val[`NBSP_CTL_MPEN];
      rx_en_reg <= ctrl_rst_val[`NBSP_CTL_RXEN];
      tx9_reg   <= ctrl_rst_val[`NBSP_CTL_TX9];
    end else if (wr_ctl) begin
      mp_en_reg <= wdata[`NBSP_CTL_MPEN];
      rx_en_reg <= wdata[`NBSP_CTL_RXEN];
      tx9_reg   <= wdata[`NBSP_CTL_TX9];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reload_reg <= `NBSP_RELOAD_RST;
      rate_reg   <= `NBSP_RATE_RST;
      ien_reg    <= `NBSP_INT_RST;
    end else if (wr_en) begin
      if (addr == `NBSP_OFS_RELOAD) begin
        reload_reg <= wdata;
      end
      if (addr == `NBSP_OFS_RATE) begin
        rate_reg <= wdata[2:0];
      end
      if (addr == `NBSP_OFS_IEN) begin
        ien_reg <= wdata[1:0];
      end
    end
  end

  // hardware set beats a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_done_reg <= ctrl_rst_val[`NBSP_CTL_TXDONE];
    end else if (tx_set) begin
      tx_done_reg <= 1'b1;
    end else if (wr_ctl) begin
      tx_done_reg <= wdata[`NBSP_CTL_TXDONE];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_done_reg <= ctrl_rst_val[`NBSP_CTL_RXDONE];
      rx9_reg     <= ctrl_rst_val[`NBSP_CTL_RX9];
      rx_buf_reg  <= 8'h00;
    end else if (rx_accept) begin
      rx_done_reg <= 1'b1;
      rx9_reg     <= rx_shift_reg[8];
      rx_buf_reg  <= rx_shift_reg[7:0];
    end else if (wr_ctl) begin
      rx_done_reg <= wdata[`NBSP_CTL_RXDONE];
      rx9_reg     <= wdata[`NBSP_CTL_RX9];
    end
  end

  // ----------------------------------------------------------------
  // read port, data only in the cycle after the strobe
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n || !rd_en) begin
      rdata_reg <= 8'h00;
    end else begin
      case (addr)
        `NBSP_OFS_CTRL:   rdata_reg <= {2'h0, mp_en_reg, rx_en_reg,
                                        tx9_reg, rx9_reg, tx_done_reg,
                                        rx_done_reg};
        `NBSP_OFS_DATA:   rdata_reg <= rx_buf_reg;
        `NBSP_OFS_RELOAD: rdata_reg <= reload_reg;
        `NBSP_OFS_RATE:   rdata_reg <= {5'h00, rate_reg};
        `NBSP_OFS_ISTAT:  rdata_reg <= {6'h00, istat_reg};
        `NBSP_OFS_IEN:    rdata_reg <= {6'h00, ien_reg};
        default:          rdata_reg <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  always_comb begin
    istat_next = istat_reg;
    if (wr_en && (addr == `NBSP_OFS_ICLR)) begin
      istat_next = istat_reg & ~wdata[1:0];
    end
    istat_next[`NBSP_INT_TX] = istat_next[`NBSP_INT_TX] | tx_set;
    istat_next[`NBSP_INT_RX] = istat_next[`NBSP_INT_RX] | rx_accept;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      istat_reg <= `NBSP_INT_RST;
      irq_reg   <= 1'b0;
    end else begin
      istat_reg <= istat_next;
      irq_reg   <= |(istat_next & ien_reg);
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  // writes while a frame is on the wire are dropped, not queued
  assign tx_load = wr_data && !tx_busy_reg;
  assign tx_set  = tx_busy_reg && ovf && tx_half_reg &&
                   (tx_idx_reg == `NBSP_TX_STOP_IDX - 4'h1);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_busy_reg  <= 1'b0;
      tx_shift_reg <= 11'h7ff;
      tx_idx_reg   <= 4'h0;
      tx_half_reg  <= 1'b0;
      txd_reg      <= 1'b1;
      tx9_sent_reg <= 1'b0;
    end else if (tx_load) begin
      tx_shift_reg <= {1'b1, tx9_reg, wdata, 1'b0};
      tx9_sent_reg <= tx9_reg;
      tx_busy_reg  <= 1'b1;
      tx_idx_reg   <= 4'h0;
      tx_half_reg  <= 1'b0;
      txd_reg      <= 1'b0;
    end else if (tx_busy_reg && ovf) begin
      tx_half_reg <= ~tx_half_reg;
      if (tx_half_reg) begin
        if (tx_idx_reg == `NBSP_TX_STOP_IDX) begin
          tx_busy_reg <= 1'b0;
          txd_reg     <= 1'b1;
        end else begin
          tx_idx_reg   <= tx_idx_reg + 4'h1;
          tx_shift_reg <= tx_shift_reg >> 1;
          txd_reg      <= tx_shift_reg[1];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  // overflow phase is free running, so sampling lands between the
  // start and the middle of each bit
  assign rx_finish = (rx_state_reg == RX_STOP) && ovf && rx_half_reg;
  assign rx_ok     = !rx_done_reg &&
                     (!mp_en_reg || rx_shift_reg[8]);
  assign rx_accept = rx_finish && rx_ok;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_state_reg <= RX_IDLE;
      rx_shift_reg <= 9'h000;
      rx_cnt_reg   <= 4'h0;
      rx_half_reg  <= 1'b0;
    end else begin
      case (rx_state_reg)
        RX_IDLE: begin
          if (rx_en_reg && !rxd) begin
            rx_state_reg <= RX_START;
          end
        end
        RX_START: begin
          if (ovf) begin
            rx_state_reg <= rxd ? RX_IDLE : RX_DATA;
            rx_cnt_reg   <= 4'h0;
            rx_half_reg  <= 1'b0;
          end
        end
        RX_DATA: begin
          if (ovf) begin
            rx_half_reg <= ~rx_half_reg;
            if (rx_half_reg) begin
              rx_shift_reg <= {rxd, rx_shift_reg[8:1]};
              rx_cnt_reg   <= rx_cnt_reg + 4'h1;
              if (rx_cnt_reg == `NBSP_RX_LAST_IDX) begin
                rx_state_reg <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          // stop level is never looked at
          if (ovf) begin
            rx_half_reg <= ~rx_half_reg;
            if (rx_half_reg) begin
              rx_state_reg <= RX_IDLE;
            end
          end
        end
        default: rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  assign rdata = rdata_reg;
  assign txd   = txd_reg;
  assign irq   = irq_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_tx_start;
    tx_load |=> !txd_reg && tx_busy_reg && tx_idx_reg == 4'h0;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("write did not start a frame");

  property p_tx_done;
    tx_set |=> tx_done_reg && txd_reg &&
               tx_idx_reg == `NBSP_TX_STOP_IDX;
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("tx done not set at stop bit start");

  property p_tx_ninth;
    tx_busy_reg && tx_idx_reg == 4'h9 |-> txd_reg == tx9_sent_reg;
  endproperty
  a_tx_ninth: assert property (p_tx_ninth)
    else $error("wrong ninth bit on the line");

  property p_tx_frame;
    tx_busy_reg && tx_idx_reg == 4'h0 && ovf && tx_half_reg
      |=> tx_idx_reg == 4'h1 && txd_reg == $past(tx_shift_reg[1]);
  endproperty
  a_tx_frame: assert property (p_tx_frame)
    else $error("start bit length wrong");

  sequence s_rx_good;
    rx_finish && !rx_done_reg && (!mp_en_reg || rx_shift_reg[8]);
  endsequence

  property p_rx_accept;
    s_rx_good |=> rx_done_reg && rx_buf_reg == $past(rx_shift_reg[7:0])
                  && rx9_reg == $past(rx_shift_reg[8]);
  endproperty
  a_rx_accept: assert property (p_rx_accept)
    else $error("accepted frame not stored");

  property p_rx_reject;
    rx_finish && !rx_ok && !wr_ctl |=>
      $stable(rx_buf_reg) && $stable(rx9_reg) && $stable(rx_done_reg);
  endproperty
  a_rx_reject: assert property (p_rx_reject)
    else $error("rejected frame changed receive state");

  property p_rx_filter;
    rx_finish && mp_en_reg && !rx_shift_reg[8] && !wr_ctl
      |=> !rx_done_reg;
  endproperty
  a_rx_filter: assert property (p_rx_filter)
    else $error("filtered frame was accepted");

  property p_rx_enable;
    rx_state_reg == RX_IDLE && !rx_en_reg |=> rx_state_reg == RX_IDLE;
  endproperty
  a_rx_enable: assert property (p_rx_enable)
    else $error("receiver left idle while disabled");

  property p_irq;
    (tx_set && ien_reg[`NBSP_INT_TX]) or
    (rx_accept && ien_reg[`NBSP_INT_RX]) |=> irq_reg;
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt not raised on enabled event");
endmodule : nbsp_top
`default_nettype wire

// *** hw/nbsp_consts.svh ***
`ifndef NBSP_CONSTS_SVH
`define NBSP_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define NBSP_OFS_CTRL    3'h0
`define NBSP_OFS_DATA    3'h1
`define NBSP_OFS_RELOAD  3'h2
`define NBSP_OFS_RATE    3'h3
`define NBSP_OFS_ISTAT   3'h4
`define NBSP_OFS_ICLR    3'h5
`define NBSP_OFS_IEN     3'h6

// ----------------------------------------------------------------
// serial_control_reg fields
// ----------------------------------------------------------------
`define NBSP_CTL_RXDONE  0
`define NBSP_CTL_TXDONE  1
`define NBSP_CTL_RX9     2
`define NBSP_CTL_TX9     3
`define NBSP_CTL_RXEN    4
`define NBSP_CTL_MPEN    5

// ----------------------------------------------------------------
// rate config, interrupt fields
// ----------------------------------------------------------------
`define NBSP_RATE_SYSTEM_CLOCK 0
`define NBSP_RATE_PS_LO  1
`define NBSP_RATE_PS_HI  2
`define NBSP_INT_RX      0
`define NBSP_INT_TX      1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define NBSP_CTRL_RST    8'h00
`define NBSP_RELOAD_RST  8'h00
`define NBSP_RATE_RST    3'h0
`define NBSP_INT_RST     2'h0

// ----------------------------------------------------------------
// frame and timer counts
// ----------------------------------------------------------------
`define NBSP_TX_STOP_IDX 4'ha
`define NBSP_RX_LAST_IDX 4'h8
`define NBSP_CNT_TOP     8'hff
`define NBSP_PS_CODE12   2'h0
`define NBSP_PS_CODE4    2'h1
`define NBSP_PS_CODE48   2'h2
`define NBSP_PS_DIV12    6'h0c
`define NBSP_PS_DIV4     6'h04
`define NBSP_PS_DIV48    6'h30

`endif

// *** hw/nbsp_pkg.sv ***
`default_nettype none
package nbsp_pkg;
  typedef logic [7:0] nbsp_data_type;
  typedef logic [2:0] nbsp_addr_type;
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } nbsp_rx_state_type;
endpackage : nbsp_pkg
`default_nettype wire

// *** hw/nbsp_rate_if.sv ***
`default_nettype none
interface nbsp_rate_if;
  logic [7:0] reload;
  logic       system_clock_sel;
  logic [1:0] prescale_sel;
  logic       ovf;
  modport ctl (output reload, output system_clock_sel, output prescale_sel,
               input ovf);
  modport tmr (input reload, input system_clock_sel, input prescale_sel,
               output ovf);
endinterface : nbsp_rate_if
`default_nettype wire

// *** hw/nbsp_rate.sv ***
`include "nbsp_consts.svh"
`default_nettype none
module nbsp_rate (
  input wire logic clk,
  input wire logic rst_n,
  nbsp_rate_if.tmr rif
);
  import nbsp_pkg::*;

  logic [5:0] pre_cnt_reg;
  logic [5:0] pre_div;
  logic       pre_tick;
  logic       tmr_tick;
  logic [7:0] cnt_reg;
  logic       ovf_reg;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  always_comb begin
    case (rif.prescale_sel)
      `NBSP_PS_CODE12: pre_div = `NBSP_PS_DIV12;
      `NBSP_PS_CODE4:  pre_div = `NBSP_PS_DIV4;
      `NBSP_PS_CODE48: pre_div = `NBSP_PS_DIV48;
      default:         pre_div = `NBSP_PS_DIV12;
    endcase
  end

  // a count stranded above a new top clears to zero on the next clock, no short tick
  assign pre_tick = (pre_cnt_reg == pre_div - 6'h01);
  assign tmr_tick = rif.system_clock_sel | pre_tick;

  always_ff @(posedge clk) begin
    if (!rst_n || pre_cnt_reg >= pre_div - 6'h01) begin
      pre_cnt_reg <= 6'h00;
    end else begin
      pre_cnt_reg <= pre_cnt_reg + 6'h01;
    end
  end

  // ----------------------------------------------------------------
  // reloading counter, one overflow per half bit
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_reg <= 8'h00;
      ovf_reg <= 1'b0;
    end else begin
      ovf_reg <= 1'b0;
      if (tmr_tick) begin
        if (cnt_reg == `NBSP_CNT_TOP) begin
          cnt_reg <= rif.reload;
          ovf_reg <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 8'h01;
        end
      end
    end
  end

  assign rif.ovf = ovf_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_reload;
    ovf_reg && $past(rif.system_clock_sel) |-> cnt_reg == $past(rif.reload);
  endproperty
  a_reload: assert property (p_reload)
    else $error("counter not reloaded at overflow");

  property p_prescale;
    tmr_tick && !rif.system_clock_sel |-> pre_cnt_reg == pre_div - 6'h01;
  endproperty
  a_prescale: assert property (p_prescale)
    else $error("prescaler tick at wrong count");
endmodule : nbsp_rate
`default_nettype wire

// *** tb/nbsp_peer.sv ***
`default_nettype none
module nbsp_peer (
  input  wire logic clk,
  input  wire logic txd,
  output var  logic rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // far node state
  // ----------
  int         bit_cyc = 8;
  int         got_cnt = 0;
  logic [9:0] got     = '0;
  initial rxd = 1'b1;
  // ----------
  // frame capture
  // ----------
  // quarter bit late: the sender's start bit may be short
  always begin
    @(negedge txd);
    repeat (bit_cyc / 4) @(posedge clk);
    if (txd === 1'b0) begin
      for (int i = 0; i < 10; i++) begin
        repeat (bit_cyc) @(posedge clk);
        got[i] = txd;
      end
      got_cnt++;
    end
  end
  // ----------
  // frame launch
  // ----------
  // stop_bit low only where a test wants a broken frame
  task automatic send(input logic [8:0] d, input logic stop_bit);
    logic [10:0] f;
    @(posedge clk);
    f = {stop_bit, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd <= f[i];
      repeat (bit_cyc) @(posedge clk);
    end
    rxd <= 1'b1;
  endtask : send
endmodule : nbsp_peer
`default_nettype wire

// *** tb/nbsp_tb_top.sv ***
`include "nbsp_consts.svh"
`default_nettype none
module nbsp_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import nbsp_pkg::*;
  // ----------
  // signals
  // ----------
  logic          clk        = 1'b0;
  logic          rst_n      = 1'b0;
  nbsp_addr_type addr       = '0;
  nbsp_data_type wdata      = '0;
  logic          wr_en      = 1'b0;
  logic          rd_en      = 1'b0;
  nbsp_data_type rdata;
  logic          rxd;
  logic          txd;
  logic          irq;
  int            bad_count  = 0;
  int            num_checks = 0;
  logic [15:0]   lfsr       = 16'h0051;
  nbsp_data_type v;
  nbsp_data_type d;
  logic          n9;
  int            c0;
  // last entry drives the spare prescale code, which divides by 12
  int            bits[5]    = '{8, 8, 24, 96, 24};
  int            divs[5]    = '{1, 4, 12, 48, 12};
  logic [1:0]    codes[5]   = '{`NBSP_PS_CODE12, `NBSP_PS_CODE4,
                                `NBSP_PS_CODE12, `NBSP_PS_CODE48, 2'h3};
  always #2.5 clk = ~clk;
  nbsp_top DUT (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .rxd(rxd), .txd(txd),
    .irq(irq));
  nbsp_peer peer (.clk(clk), .txd(txd), .rxd(rxd));
  // ----------
  // helpers
  // ----------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // a bit is two overflows of (256 - reload) ticks
  function automatic nbsp_data_type reload_for(input int bc, input int dv);
    return 8'(256 - bc / (2 * dv));
  endfunction : reload_for
  function automatic nbsp_data_type fl(input int p);
    return 8'h01 << p;
  endfunction : fl
  task automatic wr(input nbsp_addr_type a, input nbsp_data_type x);
    @(posedge clk);
    addr  <= a;
    wdata <= x;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask : wr
  task automatic rd(input nbsp_addr_type a, output nbsp_data_type x);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 x = rdata;
  endtask : rd
  task automatic chk_reg(input string n, input nbsp_data_type e,
                         input nbsp_data_type g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_frame(input string n, input logic [9:0] e,
                           input logic [9:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk_frame
  task automatic rd_chk(input nbsp_addr_type a, input nbsp_data_type e,
                        input string n);
    rd(a, v);
    chk_reg(n, e, v);
  endtask : rd_chk
  // polling is bounded so a dead flag cannot hang the run
  task automatic wait_ist(input int b);
    for (int n = 0; n < 4000; n++) begin
      rd(`NBSP_OFS_ISTAT, v);
      if (v[b] === 1'b1) break;
    end
    chk_reg("flag wait", 8'h01, {7'h0, v[b]});
  endtask : wait_ist
  task automatic conclude;
    $display("checks %0d bad %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : conclude
  // ----------
  // sequence
  // ----------
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk_reg("irq", 8'h00, {7'h0, irq});
    rd_chk(`NBSP_OFS_CTRL, `NBSP_CTRL_RST, "ctrl");
    rd_chk(`NBSP_OFS_RATE, 8'(`NBSP_RATE_RST), "rate");
    rd_chk(`NBSP_OFS_ISTAT, 8'(`NBSP_INT_RST), "istat");
    lfsr = lfsr_next(lfsr);
    wr(`NBSP_OFS_RELOAD, lfsr[7:0]);
    rd_chk(`NBSP_OFS_RELOAD, lfsr[7:0], "reload");
    wr(3'h7, 8'hff);
    rd_chk(3'h7, 8'h00, "unmapped");
    wr(`NBSP_OFS_IEN, 8'h03);
    for (int k = 0; k < 5; k++) begin
      wr(`NBSP_OFS_RELOAD, reload_for(bits[k], divs[k]));
      wr(`NBSP_OFS_RATE, {5'h0, codes[k], k == 0});
      peer.bit_cyc = bits[k];
      repeat (300) @(posedge clk);
      for (int j = 0; j < 2; j++) begin
        lfsr = lfsr_next(lfsr);
        d  = lfsr[7:0];
        n9 = j[0];
        c0 = peer.got_cnt;
        wr(`NBSP_OFS_CTRL, n9 ? fl(`NBSP_CTL_TX9) : 8'h00);
        wr(`NBSP_OFS_DATA, d);
        wr(`NBSP_OFS_DATA, ~d);
        rd_chk(`NBSP_OFS_ISTAT, 8'h00, "istat mid frame");
        wait_ist(`NBSP_INT_TX);
        chk_reg("txd at done", 8'h01, {7'h0, txd});
        chk_reg("irq", 8'h01, {7'h0, irq});
        for (int n = 0; n < 2000 && peer.got_cnt == c0; n++)
          @(posedge clk);
        chk_reg("frames", 8'(c0 + 1), 8'(peer.got_cnt));
        chk_frame("frame", {1'b1, n9, d}, peer.got);
        repeat (bits[k]) @(posedge clk);
        wr(`NBSP_OFS_ICLR, fl(`NBSP_INT_TX));
        wr(`NBSP_OFS_CTRL, 8'h00);
        rd_chk(`NBSP_OFS_ISTAT, 8'h00, "istat clear");
        chk_reg("irq", 8'h00, {7'h0, irq});
      end
    end
    wr(`NBSP_OFS_RELOAD, reload_for(8, 1));
    wr(`NBSP_OFS_RATE, 8'h01);
    peer.bit_cyc = 8;
    repeat (300) @(posedge clk);
    lfsr = lfsr_next(lfsr);
    d = lfsr[7:0];
    peer.send({1'b1, ~d}, 1'b1);
    repeat (16) @(posedge clk);
    rd_chk(`NBSP_OFS_CTRL, 8'h00, "ctrl rx off");
    wr(`NBSP_OFS_CTRL, fl(`NBSP_CTL_RXEN));
    // broken stop bit must still be taken
    peer.send({1'b0, d}, 1'b0);
    repeat (16) @(posedge clk);
    rd_chk(`NBSP_OFS_CTRL, fl(`NBSP_CTL_RXEN) | fl(`NBSP_CTL_RXDONE),
           "ctrl rx");
    rd_chk(`NBSP_OFS_DATA, d, "rx data");
    chk_reg("irq", 8'h01, {7'h0, irq});
    wr(`NBSP_OFS_IEN, 8'h00);
    rd_chk(`NBSP_OFS_IEN, 8'h00, "ien");
    chk_reg("irq masked", 8'h00, {7'h0, irq});
    wr(`NBSP_OFS_IEN, 8'h03);
    repeat (100) @(posedge clk);
    peer.send({1'b1, ~d}, 1'b1);
    repeat (16) @(posedge clk);
    rd_chk(`NBSP_OFS_DATA, d, "rx kept");
    rd_chk(`NBSP_OFS_CTRL, fl(`NBSP_CTL_RXEN) | fl(`NBSP_CTL_RXDONE),
           "ctrl kept");
    wr(`NBSP_OFS_CTRL, fl(`NBSP_CTL_RXEN) | fl(`NBSP_CTL_MPEN));
    wr(`NBSP_OFS_ICLR, fl(`NBSP_INT_RX));
    peer.send({1'b0, ~d}, 1'b1);
    repeat (16) @(posedge clk);
    rd_chk(`NBSP_OFS_CTRL, fl(`NBSP_CTL_RXEN) | fl(`NBSP_CTL_MPEN),
           "ctrl filtered");
    rd_chk(`NBSP_OFS_DATA, d, "rx filtered");
    rd_chk(`NBSP_OFS_ISTAT, 8'h00, "istat filtered");
    peer.send({1'b1, ~d}, 1'b1);
    repeat (16) @(posedge clk);
    rd_chk(`NBSP_OFS_CTRL, fl(`NBSP_CTL_RXEN) | fl(`NBSP_CTL_MPEN) |
           fl(`NBSP_CTL_RX9) | fl(`NBSP_CTL_RXDONE),
           "ctrl addr");
    rd_chk(`NBSP_OFS_DATA, ~d, "rx addr");
    conclude();
  end
  // ----------
  // watchdog
  // ----------
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : nbsp_tb_top
`default_nettype wire
